// file: dma_engine.sv
// fourteen-channel dma engine with register slave and interrupts
`default_nettype none
module dma_engine (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register slave
  input wire logic [8:0] s_address,
  input wire logic s_read,
  input wire logic s_write,
  input wire logic [31:0] s_writedata,
  input wire logic [3:0] s_byteenable,
  output logic [31:0] s_readdata,
  output logic s_waitrequest,
  // data master
  output logic [31:0] m_address,
  output logic m_read,
  output logic m_write,
  output logic [31:0] m_writedata,
  output logic [3:0] m_byteenable,
  input wire logic [31:0] m_readdata,
  input wire logic m_waitrequest,
  input wire logic [1:0] m_response,
  // peripheral handshake
  input wire logic [dma_pkg::NUM_CH-1:0] dreq,
  output logic [dma_pkg::NUM_CH-1:0] dack,
  // timer events and power state
  input wire logic [dma_pkg::NUM_CH-1:0] tmr_evt,
  input wire logic stop_mode,
  // interrupts
  output logic [dma_pkg::NUM_CH-1:0] chan_irq,
  output logic irq
);
  localparam int NCH = dma_pkg::NUM_CH;
  localparam int NEV = dma_pkg::NUM_EVT;
  localparam int CPC = dma_pkg::CH_PER_CTRL;
  localparam int IW = $clog2(CPC);
  // per-channel programming
  logic [dma_pkg::CFG_W-1:0] cfg_q [NCH], cfg_d [NCH]; // channel config
  logic [dma_pkg::CNT_W-1:0] cnt_q [NCH], cnt_d [NCH]; // items left
  logic [dma_pkg::CNT_W-1:0] pcnt_q [NCH], pcnt_d [NCH]; // programmed count
  logic [31:0] src_q [NCH], src_d [NCH]; // current source
  logic [31:0] dst_q [NCH], dst_d [NCH]; // current destination
  logic [31:0] psrc_q [NCH], psrc_d [NCH]; // programmed source
  logic [31:0] pdst_q [NCH], pdst_d [NCH]; // programmed destination
  // event flags and their enables
  logic [NCH-1:0] flag_q [NEV], flag_d [NEV];
  logic [NCH-1:0] ien_q [NEV], ien_d [NEV];
  logic [NCH-1:0] evt_set [NEV]; // hardware set this cycle
  logic [NCH-1:0] evt_clr [NEV]; // software clear this cycle
  // request tracking
  logic [NCH-1:0] pend_q, pend_d; // latched request edges
  logic [NCH-1:0] dprev_q, dprev_d; // request delayed
  logic [NCH-1:0] tgo_q, tgo_d; // timer-armed block
  logic [NCH-1:0] elig; // channels asking for service
  logic [dma_pkg::PRIO_W*NCH-1:0] prio_all; // packed levels
  // service sequencing
  logic run_q, run_d; // an item is in the mover
  logic [dma_pkg::CH_W-1:0] act_q, act_d; // channel in service
  logic start_q, start_d; // item request pulse
  logic [NCH-1:0] dack_q, dack_d; // item served pulse
  logic [NCH-1:0] cirq_q, cirq_d; // per-channel line
  logic irq_q, irq_d; // combined line
  // arbiter results
  logic g_vld [dma_pkg::NUM_CTRL];
  logic [IW-1:0] g_idx [dma_pkg::NUM_CTRL];
  logic [dma_pkg::PRIO_W-1:0] g_prio [dma_pkg::NUM_CTRL];
  logic [dma_pkg::CH_W-1:0] sel_ch; // overall winner
  logic any_vld; // some controller has a winner
  // register slave
  logic swait_q, swait_d; // waitrequest
  logic [31:0] srd_q, srd_d; // read data
  logic acc; // access taken this cycle
  logic wr_acc; // write taken this cycle
  logic in_ch; // channel area hit
  logic [dma_pkg::CH_W-1:0] a_ch; // addressed channel
  logic [1:0] a_ev; // addressed event group
  logic ev_ok; // event index mapped
  logic [31:0] rd_val; // read mux
  logic [dma_pkg::CNT_W-1:0] ncnt; // count after an item
  logic [dma_pkg::CH_W-1:0] a; // shorthand for act_q
  xfer_if xf ();

  // address decode shared by reads and writes
  always_comb begin
    acc = swait_q && (s_read || s_write);
    wr_acc = acc && s_write;
    a_ch = s_address[7:4];
    a_ev = s_address[3:2];
    in_ch = !s_address[8] && (32'(a_ch) < NCH);
    ev_ok = (32'(a_ev) < NEV) && (s_address[1:0] == 2'h0);
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_val = '0;
    if (in_ch) begin
      case (s_address[3:0])
        dma_pkg::OFF_CFG: rd_val = 32'(cfg_q[a_ch]);
        dma_pkg::OFF_CNT: rd_val = 32'(cnt_q[a_ch]);
        dma_pkg::OFF_SRC: rd_val = src_q[a_ch];
        dma_pkg::OFF_DST: rd_val = dst_q[a_ch];
        default: rd_val = '0;
      endcase
    end else if (ev_ok && {s_address[8:4], 4'h0} == dma_pkg::OFF_STAT) begin
      rd_val = 32'(flag_q[a_ev]);
    end else if (ev_ok && {s_address[8:4], 4'h0} == dma_pkg::OFF_IEN) begin
      rd_val = 32'(ien_q[a_ev]);
    end
  end

  // slave answer: waitrequest drops one cycle after the request
  always_comb begin
    swait_d = 1'b1;
    srd_d = srd_q;
    if (acc) begin
      swait_d = 1'b0;
      srd_d = s_read ? rd_val : '0;
    end
  end

  // levels packed for the arbiters
  always_comb begin
    prio_all = '0;
    for (int i = 0; i < NCH; i++) begin
      prio_all[dma_pkg::PRIO_W*i +: dma_pkg::PRIO_W] =
        cfg_q[i][dma_pkg::CFG_PRIO +: dma_pkg::PRIO_W]; // R3
    end
  end

  // who is asking: hardware edge, software, or timer arm
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      elig[i] = 1'b0;
      if (cfg_q[i][dma_pkg::CFG_EN] && cnt_q[i] != '0) begin
        case (cfg_q[i][dma_pkg::CFG_TRIG +: 2])
          dma_pkg::TRIG_HW: elig[i] = pend_q[i]; // R2 R9
          dma_pkg::TRIG_SW: elig[i] = 1'b1; // R2 R9
          dma_pkg::TRIG_TMR: elig[i] = tgo_q[i]; // R12
          default: elig[i] = 1'b0;
        endcase
      end
    end
  end

  // one arbiter per controller
  for (genvar c = 0; c < dma_pkg::NUM_CTRL; c++) begin : g_ctrl
    prio_arbiter #(.N(CPC)) u_arb (
      .req(elig[c*CPC +: CPC]),
      .prio(prio_all[dma_pkg::PRIO_W*c*CPC +: dma_pkg::PRIO_W*CPC]),
      .gnt_vld(g_vld[c]),
      .gnt_idx(g_idx[c]),
      .gnt_prio(g_prio[c])
    ); // R1
  end

  // between controllers: higher level, first controller on a tie
  always_comb begin
    any_vld = g_vld[0] || g_vld[1];
    if (g_vld[1] && (!g_vld[0] || g_prio[1] > g_prio[0])) begin
      sel_ch = dma_pkg::CH_W'(CPC) + dma_pkg::CH_W'(g_idx[1]);
    end else begin
      sel_ch = dma_pkg::CH_W'(g_idx[0]);
    end
  end

  // channel state: service, completion, software access, flags
  always_comb begin
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    pcnt_d = pcnt_q;
    src_d = src_q;
    dst_d = dst_q;
    psrc_d = psrc_q;
    pdst_d = pdst_q;
    ien_d = ien_q;
    run_d = run_q;
    act_d = act_q;
    start_d = 1'b0;
    dack_d = '0;
    pend_d = pend_q;
    tgo_d = tgo_q;
    dprev_d = dreq;
    ncnt = cnt_q[act_q] - dma_pkg::CNT_W'(1);
    a = act_q;
    for (int e = 0; e < NEV; e++) begin
      evt_set[e] = '0;
      evt_clr[e] = '0;
    end
    // issue one item to the mover
    if (!run_q && any_vld) begin
      start_d = 1'b1;
      run_d = 1'b1;
      act_d = sel_ch;
      pend_d[sel_ch] = 1'b0;
    end
    // item finished
    if (xf.done) begin
      run_d = 1'b0;
      if (xf.err) begin
        evt_set[dma_pkg::EVT_TE][a] = 1'b1; // R14
        cfg_d[a][dma_pkg::CFG_EN] = 1'b0; // R14
      end else begin
        // fixed address on a peripheral side, stepping on memory
        if (cfg_q[a][dma_pkg::CFG_SINC]) begin // R9
          src_d[a] = src_q[a] + dma_pkg::size_step(cfg_q[a][dma_pkg::CFG_SSZ +: 2]);
        end
        if (cfg_q[a][dma_pkg::CFG_DINC]) begin // R9
          dst_d[a] = dst_q[a] + dma_pkg::size_step(cfg_q[a][dma_pkg::CFG_DSZ +: 2]);
        end
        cnt_d[a] = ncnt; // R10
        if (ncnt == (pcnt_q[a] >> 1)) begin
          evt_set[dma_pkg::EVT_HT][a] = 1'b1; // R13
        end
        if (ncnt == '0) begin
          evt_set[dma_pkg::EVT_TC][a] = 1'b1; // R13
          tgo_d[a] = 1'b0;
          if (cfg_q[a][dma_pkg::CFG_CIRC]) begin
            // restart the same buffer
            cnt_d[a] = pcnt_q[a]; // R7
            src_d[a] = psrc_q[a]; // R7
            dst_d[a] = pdst_q[a]; // R7
          end else begin
            cfg_d[a][dma_pkg::CFG_EN] = 1'b0;
          end
        end
        if (cfg_q[a][dma_pkg::CFG_TRIG +: 2] == dma_pkg::TRIG_HW) begin
          dack_d[a] = 1'b1; // R2
        end
      end
    end
    // software writes win over hardware updates of the same word
    if (wr_acc && in_ch) begin
      case (s_address[3:0])
        dma_pkg::OFF_CFG: begin
          cfg_d[a_ch] = dma_pkg::CFG_W'(dma_pkg::be_merge(32'(cfg_q[a_ch]),
                                                          s_writedata, s_byteenable));
          tgo_d[a_ch] = 1'b0;
        end
        dma_pkg::OFF_CNT: begin
          cnt_d[a_ch] = dma_pkg::CNT_W'(dma_pkg::be_merge(32'(cnt_q[a_ch]),
                                                          s_writedata, s_byteenable)); // R10
          pcnt_d[a_ch] = cnt_d[a_ch];
        end
        dma_pkg::OFF_SRC: begin
          src_d[a_ch] = dma_pkg::be_merge(src_q[a_ch], s_writedata, s_byteenable); // R11
          psrc_d[a_ch] = src_d[a_ch];
        end
        dma_pkg::OFF_DST: begin
          dst_d[a_ch] = dma_pkg::be_merge(dst_q[a_ch], s_writedata, s_byteenable); // R11
          pdst_d[a_ch] = dst_d[a_ch];
        end
        default: begin
        end
      endcase
    end
    // clear and enable registers
    if (wr_acc && ev_ok) begin
      if ({s_address[8:4], 4'h0} == dma_pkg::OFF_CLR) begin
        evt_clr[a_ev] = NCH'(dma_pkg::be_merge('0, s_writedata, s_byteenable));
      end
      if ({s_address[8:4], 4'h0} == dma_pkg::OFF_IEN) begin
        ien_d[a_ev] = NCH'(dma_pkg::be_merge(32'(ien_q[a_ev]), s_writedata, s_byteenable));
      end
    end
    // new request edges and timer arms, set wins over clear
    pend_d = pend_d | (dreq & ~dprev_q); // R2
    for (int i = 0; i < NCH; i++) begin
      if (tmr_evt[i] && !stop_mode &&
          cfg_q[i][dma_pkg::CFG_TRIG +: 2] == dma_pkg::TRIG_TMR) begin
        tgo_d[i] = 1'b1; // R12
      end
    end
    // sticky flags: clear first, then events
    for (int e = 0; e < NEV; e++) begin
      flag_d[e] = (flag_q[e] & ~evt_clr[e]) | evt_set[e]; // R8
    end
  end

  // interrupt lines from the enabled flags
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cirq_d[i] = 1'b0;
      for (int e = 0; e < NEV; e++) begin
        cirq_d[i] = cirq_d[i] | (flag_q[e][i] & ien_q[e][i]); // R8
      end
    end
    irq_d = |cirq_d;
  end

  // all registers of the engine
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '{default: '0};
      cnt_q <= '{default: '0};
      pcnt_q <= '{default: '0};
      src_q <= '{default: '0};
      dst_q <= '{default: '0};
      psrc_q <= '{default: '0};
      pdst_q <= '{default: '0};
      flag_q <= '{default: '0};
      ien_q <= '{default: '0};
      pend_q <= '0;
      dprev_q <= '0;
      tgo_q <= '0;
      run_q <= 1'b0;
      act_q <= '0;
      start_q <= 1'b0;
      dack_q <= '0;
      cirq_q <= '0;
      irq_q <= 1'b0;
      swait_q <= 1'b1;
      srd_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      pcnt_q <= pcnt_d;
      src_q <= src_d;
      dst_q <= dst_d;
      psrc_q <= psrc_d;
      pdst_q <= pdst_d;
      flag_q <= flag_d;
      ien_q <= ien_d;
      pend_q <= pend_d;
      dprev_q <= dprev_d;
      tgo_q <= tgo_d;
      run_q <= run_d;
      act_q <= act_d;
      start_q <= start_d;
      dack_q <= dack_d;
      cirq_q <= cirq_d;
      irq_q <= irq_d;
      swait_q <= swait_d;
      srd_q <= srd_d;
    end
  end

  // item description follows the channel in service
  assign xf.start = start_q;
  assign xf.src = src_q[act_q];
  assign xf.dst = dst_q[act_q];
  assign xf.ssize = cfg_q[act_q][dma_pkg::CFG_SSZ +: 2]; // R5
  assign xf.dsize = cfg_q[act_q][dma_pkg::CFG_DSZ +: 2]; // R5

  // data mover
  xfer_mover u_mover (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .xf(xf.mover),
    .m_address(m_address),
    .m_read(m_read),
    .m_write(m_write),
    .m_writedata(m_writedata),
    .m_byteenable(m_byteenable),
    .m_readdata(m_readdata),
    .m_waitrequest(m_waitrequest),
    .m_response(m_response)
  );

  // registered outputs
  assign s_readdata = srd_q;
  assign s_waitrequest = swait_q;
  assign dack = dack_q;
  assign chan_irq = cirq_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// file: dma_engine_monitor.sv
// port checker of the dma engine
`default_nettype none
module dma_engine_monitor (
  // clock, reset and watched ports
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_read,
  input wire logic s_write,
  input wire logic s_waitrequest,
  input wire logic [31:0] m_address,
  input wire logic m_read,
  input wire logic m_write,
  input wire logic m_waitrequest,
  input wire logic [1:0] m_response,
  input wire logic [13:0] dack,
  input wire logic [13:0] chan_irq,
  input wire logic irq
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a data read finishing cleanly or with a bus fault
  sequence rd_ok; m_read && !m_waitrequest && m_response == 2'h0; endsequence
  sequence rd_bad; m_read && !m_waitrequest && m_response != 2'h0; endsequence
  slave_answer_a: assert property ((s_read || s_write) && s_waitrequest |=> !s_waitrequest)
    else $error("access not answered");
  wait_pulse_a: assert property (!s_waitrequest |=> s_waitrequest)
    else $error("answer too long");
  read_hold_a: assert property (m_read && m_waitrequest |=> m_read && $stable(m_address))
    else $error("stalled read released");
  word_align_a: assert property (m_read || m_write |-> m_address[1:0] == 2'h0)
    else $error("unaligned data address");
  pack_write_a: assert property (rd_ok |=> m_write)
    else $error("no write after read");
  err_stop_a: assert property (rd_bad |=> !m_write [*3])
    else $error("write after faulty read");
  ack_pulse_a: assert property (|dack |=> dack == 14'h0)
    else $error("ack longer than one cycle");
  irq_raise_a: assert property (|chan_irq [*2] |-> irq)
    else $error("irq missing");
endmodule
bind dma_engine dma_engine_monitor mon (.*);
`default_nettype wire

// file: dma_pkg.sv
// shared constants and helpers of the dma engine
`default_nettype none
// Overview of operation
// R1: two controllers of seven channels, fourteen total
// R2: hardware request or software trigger, software selected
// R3: per-controller arbiter, four programmable priority levels
// R4: equal level: lower channel number wins
// R5: independent source/destination width, pack and unpack
// R6: software keeps addresses aligned to access width
// R7: circular mode reloads buffer without software
// R8: half, complete, error flags ORed per channel
// R9: memory and peripheral in any direction
// R10: item count programmable up to 65536
// R11: any bus target as source or destination
// R12: timer event triggers transfer except in stop
// R13: half flag at half count, complete at zero
// R14: bus error sets error flag, stops channel
package dma_pkg;
  // geometry
  localparam int NUM_CTRL = 2;
  localparam int CH_PER_CTRL = 7;
  localparam int NUM_CH = 14;
  localparam int CH_W = 4;
  localparam int NUM_EVT = 3;
  localparam int CNT_W = 17;
  localparam int CFG_W = 12;
  localparam int PRIO_W = 2;
  localparam int BYTE_BITS = 8;
  // register byte offsets inside a channel
  localparam logic [3:0] OFF_CFG = 4'h0;
  localparam logic [3:0] OFF_CNT = 4'h4;
  localparam logic [3:0] OFF_SRC = 4'h8;
  localparam logic [3:0] OFF_DST = 4'hc;
  // global register groups, event index in bits 3:2
  localparam logic [8:0] OFF_STAT = 9'h100;
  localparam logic [8:0] OFF_CLR = 9'h110;
  localparam logic [8:0] OFF_IEN = 9'h120;
  // config field positions
  localparam int CFG_EN = 0;
  localparam int CFG_CIRC = 1;
  localparam int CFG_SINC = 2;
  localparam int CFG_DINC = 3;
  localparam int CFG_SSZ = 4;
  localparam int CFG_DSZ = 6;
  localparam int CFG_PRIO = 8;
  localparam int CFG_TRIG = 10;
  // event indexes
  localparam int EVT_HT = 0;
  localparam int EVT_TC = 1;
  localparam int EVT_TE = 2;
  // access sizes and trigger sources
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] TRIG_HW = 2'h0;
  localparam logic [1:0] TRIG_SW = 2'h1;
  localparam logic [1:0] TRIG_TMR = 2'h2;
  // byte lanes of one access, word for any other code
  function automatic logic [3:0] size_be(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_be = 4'h1;
      SZ_HALF: size_be = 4'h3;
      default: size_be = 4'hf;
    endcase
  endfunction
  // address step of one access
  function automatic logic [31:0] size_step(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_step = 32'h1;
      SZ_HALF: size_step = 32'h2;
      default: size_step = 32'h4;
    endcase
  endfunction
  // expand byte lanes into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{BYTE_BITS{be[3]}}, {BYTE_BITS{be[2]}}, {BYTE_BITS{be[1]}}, {BYTE_BITS{be[0]}}};
  endfunction
  // byte-enabled write merge
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction
endpackage
`default_nettype wire

// file: mem_model.sv
// word memory answering the engine's data master
`default_nettype none
module mem_model (
  // clock, reset, stall and fault control
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic [31:0] err_addr,
  // avalon slave side
  input wire logic [31:0] m_address,
  input wire logic m_read,
  input wire logic m_write,
  input wire logic [31:0] m_writedata,
  input wire logic [3:0] m_byteenable,
  output logic [31:0] m_readdata,
  output logic m_waitrequest,
  output logic [1:0] m_response
);
  logic [31:0] mem [0:63]; // word store, preloaded by the bench
  logic [1:0] wait_q; // cycles the request has waited
  logic hit; // answering in this cycle
  // answer at once, or after two stall cycles when slow
  always_comb begin
    hit = (m_read || m_write) && (!slow || wait_q == 2'h2);
    m_waitrequest = !hit;
    m_response = (hit && m_address == err_addr) ? 2'h2 : 2'h0;
    m_readdata = hit ? mem[m_address[7:2]] : ~mem[m_address[7:2]]; // junk off the answer
  end
  // stall counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wait_q <= 2'h0;
    else wait_q <= (hit || !(m_read || m_write)) ? 2'h0 : wait_q + 2'h1;
  end
  // byte-lane write, skipped on a faulted access
  always @(posedge clk_sys) begin
    if (hit && m_write && m_address != err_addr)
      for (int b = 0; b < 4; b++) begin
        if (m_byteenable[b]) mem[m_address[7:2]][8*b+:8] <= m_writedata[8*b+:8];
      end
  end
endmodule
`default_nettype wire

// file: multi_channel_dma_controller_test.sv
// self-checking bench of the dma engine
`default_nettype none
module multi_channel_dma_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_b = 1'b0, s_read = 1'b0, s_write = 1'b0, slow = 1'b0;
  logic stop_mode = 1'b0, s_waitrequest, m_read, m_write, m_waitrequest, irq;
  logic [8:0] s_address = 9'h0;
  logic [31:0] s_writedata = 32'h0, err_addr = 32'hfc, s_readdata, m_address, m_writedata;
  logic [31:0] m_readdata, v;
  logic [3:0] m_byteenable;
  logic [1:0] m_response;
  logic [13:0] dreq = 14'h0, tmr_evt = 14'h0, dack, chan_irq;
  int error_cnt = 0, samples_checked = 0, cycles = 0, order[$];
  always #25 clk_sys = ~clk_sys;
  dma_engine uut (.*, .s_byteenable(4'hf));
  mem_model mem_i (.*);
  // compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon access, read data left in v
  task automatic acc(input logic wr, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_address <= a;
    s_writedata <= d;
    s_write <= wr;
    s_read <= !wr;
    do @(posedge clk_sys); while (s_waitrequest !== 1'b0);
    v = s_readdata;
    s_read <= 1'b0;
    s_write <= 1'b0;
  endtask
  // program one channel, config last
  task automatic setup(input int ch, input logic [31:0] src, dst, cnt, cfg);
    acc(1'b1, 9'(ch * 16 + 4), cnt);
    acc(1'b1, 9'(ch * 16 + 8), src);
    acc(1'b1, 9'(ch * 16 + 12), dst);
    acc(1'b1, 9'(ch * 16), cfg);
  endtask
  // poll a status bit, bounded
  task automatic wait_bit(input logic [8:0] a, input int b);
    for (int n = 0; n < 100 && v[b] !== 1'b1; n++) acc(1'b0, a, 32'h0);
    chk("status bit", 32'h1, {31'h0, v[b]});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard and ack order log
  always @(posedge clk_sys) begin
    cycles++;
    for (int i = 0; i < 14; i++) if (dack[i] === 1'b1) order.push_back(i);
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    mem_i.mem[0] = 32'h44332211;
    for (int i = 1; i < 6; i++) mem_i.mem[i] = 32'ha0 + i;
    mem_i.mem[48] = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    // reset state and an unmapped place
    acc(1'b1, 9'h1f0, 32'hffffffff);
    acc(1'b0, 9'h1f0, 32'h0);
    chk("unmapped", 32'h0, v);
    acc(1'b0, 9'h000, 32'h0);
    chk("cfg reset", 32'h0, v);
    // byte source into word destination, software trigger
    setup(0, 32'h0, 32'h40, 32'h2, 32'h48d);
    wait_bit(9'h104, 0);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("unpack 0", 32'h11, mem_i.mem[16]);
    chk("unpack 1", 32'h22, mem_i.mem[17]);
    acc(1'b0, 9'h100, 32'h0);
    chk("half flag", 32'h1, v);
    acc(1'b0, 9'h004, 32'h0);
    chk("count left", 32'h0, v);
    acc(1'b1, 9'h124, 32'h1);
    acc(1'b0, 9'h104, 32'h0);
    chk("irq raised", 32'h1, {31'h0, irq});
    acc(1'b1, 9'h114, 32'h1);
    acc(1'b0, 9'h104, 32'h0);
    chk("flag cleared", 32'h0, v);
    chk("irq dropped", 32'h0, {31'h0, irq});
    // three hardware requests at once on a stalling memory
    slow <= 1'b1;
    for (int c = 1; c < 4; c++) setup(c, c * 4, 32'h80 + c * 4, 32'h1, c == 3 ? 32'h2a1 : 32'h1a1);
    dreq <= 14'he;
    wait_bit(9'h104, 2);
    chk("first grant", 32'h3, order[0]);
    chk("second grant", 32'h1, order[1]);
    chk("third grant", 32'h2, order[2]);
    for (int c = 1; c < 4; c++) chk("hw copy", 32'ha0 + c, mem_i.mem[32 + c]);
    // faulting source read stops the channel
    slow <= 1'b0;
    setup(4, 32'hfc, 32'hc0, 32'h3, 32'h4a5);
    wait_bit(9'h108, 4);
    acc(1'b0, 9'h040, 32'h0);
    chk("enable off", 32'h0, v & 32'h1);
    acc(1'b0, 9'h044, 32'h0);
    chk("count kept", 32'h3, v);
    chk("no write", 32'h0, mem_i.mem[48]);
    // timer event ignored in stop, then a circular pass
    setup(5, 32'h14, 32'hd0, 32'h1, 32'h8a3);
    stop_mode <= 1'b1;
    tmr_evt <= 14'h20;
    acc(1'b0, 9'h104, 32'h0);
    tmr_evt <= 14'h0;
    repeat (20) @(posedge clk_sys);
    acc(1'b0, 9'h104, 32'h0);
    chk("stop ignored", 32'h0, v & 32'h20);
    stop_mode <= 1'b0;
    tmr_evt <= 14'h20;
    acc(1'b0, 9'h104, 32'h0);
    tmr_evt <= 14'h0;
    wait_bit(9'h104, 5);
    chk("timer copy", 32'ha5, mem_i.mem[52]);
    acc(1'b0, 9'h054, 32'h0);
    chk("reloaded", 32'h1, v);
    acc(1'b0, 9'h050, 32'h0);
    chk("still on", 32'h1, v & 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire

// file: prio_arbiter.sv
// priority arbiter of one controller
`default_nettype none
module prio_arbiter #(
  parameter int N = dma_pkg::CH_PER_CTRL
) (
  // pending channels and their levels, 3 is very high
  input wire logic [N-1:0] req,
  input wire logic [dma_pkg::PRIO_W*N-1:0] prio,
  // winner
  output logic gnt_vld,
  output logic [$clog2(N)-1:0] gnt_idx,
  output logic [dma_pkg::PRIO_W-1:0] gnt_prio
);
  // scan from the top so an equal level lower down takes over
  always_comb begin
    gnt_vld = 1'b0;
    gnt_idx = '0;
    gnt_prio = '0;
    for (int i = N - 1; i >= 0; i--) begin
      // highest level first, lower number on a tie
      if (req[i] && (!gnt_vld || prio[dma_pkg::PRIO_W*i +: dma_pkg::PRIO_W] >= gnt_prio)) begin // R3 R4
        gnt_vld = 1'b1;
        gnt_idx = ($clog2(N))'(i);
        gnt_prio = prio[dma_pkg::PRIO_W*i +: dma_pkg::PRIO_W];
      end
    end
  end
endmodule
`default_nettype wire

// file: xfer_if.sv
// carrier between channel control and the data mover
`default_nettype none
interface xfer_if;
  logic start; // one-cycle request for one item
  logic [31:0] src; // source byte address
  logic [31:0] dst; // destination byte address
  logic [1:0] ssize; // source width code
  logic [1:0] dsize; // destination width code
  logic done; // one-cycle item finished
  logic err; // bus error, valid with done
  modport ctrl (output start, src, dst, ssize, dsize, input done, err);
  modport mover (input start, src, dst, ssize, dsize, output done, err);
endinterface
`default_nettype wire

// file: xfer_mover.sv
// one-item data mover: read source, write destination
`default_nettype none
module xfer_mover (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // item request
  xfer_if.mover xf,
  // data master
  output logic [31:0] m_address,
  output logic m_read,
  output logic m_write,
  output logic [31:0] m_writedata,
  output logic [3:0] m_byteenable,
  input wire logic [31:0] m_readdata,
  input wire logic m_waitrequest,
  input wire logic [1:0] m_response
);
  typedef enum logic [3:0] {
    MV_IDLE = 4'h1,
    MV_RD = 4'h2,
    MV_WR = 4'h4,
    MV_FIN = 4'h8
  } mv_state_type;
  mv_state_type st_q, st_d;
  logic [31:0] addr_q, addr_d; // bus address
  logic rd_q, rd_d; // read strobe
  logic wr_q, wr_d; // write strobe
  logic [31:0] wd_q, wd_d; // write data
  logic [3:0] be_q, be_d; // byte lanes
  logic [31:0] dst_q, dst_d; // held destination
  logic [1:0] ssz_q, ssz_d; // held source width
  logic [1:0] dsz_q, dsz_d; // held destination width
  logic [1:0] slo_q, slo_d; // source byte offset
  logic done_q, done_d; // finish pulse
  logic err_q, err_d; // error with finish
  logic [31:0] item; // source item right-aligned
  // next state of the mover
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    rd_d = rd_q;
    wr_d = wr_q;
    wd_d = wd_q;
    be_d = be_q;
    dst_d = dst_q;
    ssz_d = ssz_q;
    dsz_d = dsz_q;
    slo_d = slo_q;
    done_d = 1'b0;
    err_d = err_q;
    // pick the source lanes, zero-extend narrow items
    item = (m_readdata >> (32'(slo_q) * dma_pkg::BYTE_BITS))
           & dma_pkg::lane_mask(dma_pkg::size_be(ssz_q)); // R5
    unique case (st_q)
      MV_IDLE: begin
        // every target shares this master, word-aligned lanes
        if (xf.start) begin // R11
          addr_d = {xf.src[31:2], 2'h0};
          be_d = dma_pkg::size_be(xf.ssize) << xf.src[1:0]; // R6
          rd_d = 1'b1;
          dst_d = xf.dst;
          ssz_d = xf.ssize;
          dsz_d = xf.dsize;
          slo_d = xf.src[1:0];
          err_d = 1'b0;
          st_d = MV_RD;
        end
      end
      MV_RD: begin
        if (!m_waitrequest) begin
          rd_d = 1'b0;
          if (m_response != 2'h0) begin // R14
            err_d = 1'b1;
            st_d = MV_FIN;
          end else begin
            // repack into destination width, wider drops high bytes
            addr_d = {dst_q[31:2], 2'h0};
            be_d = dma_pkg::size_be(dsz_q) << dst_q[1:0]; // R5 R6
            wd_d = item << (32'(dst_q[1:0]) * dma_pkg::BYTE_BITS);
            wr_d = 1'b1;
            st_d = MV_WR;
          end
        end
      end
      MV_WR: begin
        if (!m_waitrequest) begin
          wr_d = 1'b0;
          err_d = (m_response != 2'h0); // R14
          st_d = MV_FIN;
        end
      end
      MV_FIN: begin
        done_d = 1'b1;
        st_d = MV_IDLE;
      end
    endcase
  end
  // mover registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= MV_IDLE;
      addr_q <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wd_q <= '0;
      be_q <= '0;
      dst_q <= '0;
      ssz_q <= '0;
      dsz_q <= '0;
      slo_q <= '0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wd_q <= wd_d;
      be_q <= be_d;
      dst_q <= dst_d;
      ssz_q <= ssz_d;
      dsz_q <= dsz_d;
      slo_q <= slo_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end
  assign m_address = addr_q;
  assign m_read = rd_q;
  assign m_write = wr_q;
  assign m_writedata = wd_q;
  assign m_byteenable = be_q;
  assign xf.done = done_q;
  assign xf.err = err_q;
endmodule
`default_nettype wire
